/* inc/pwm_ctrl_pkg.sv */
/*
 Constants for the PWM shutdown and soft start/stop control register bank.
 Assumes a single 125 MHz core clock and an 8-bit register port.
*/
package pwm_ctrl_pkg;
   localparam logic [7:0] ADDR_SYS_CTRL = 8'h05;
   localparam logic [7:0] ADDR_SKEW1 = 8'h11;
   localparam logic [7:0] ADDR_SKEW2 = 8'h12;
   localparam logic [7:0] ADDR_SKEW1_INV = 8'h13;
   localparam logic [7:0] ADDR_SKEW2_INV = 8'h14;
   localparam logic [7:0] ADDR_HOLD_GROUP = 8'h19;
   localparam logic [7:0] ADDR_PERIOD = 8'h1a;
   localparam logic [7:0] ADDR_TRIM = 8'h1b;
   localparam logic [7:0] ADDR_RECOVERY = 8'h1c;
   localparam logic [7:0] ADDR_STATUS = 8'h1d;

   localparam logic [7:0] RST_SKEW_A = 8'hac;
   localparam logic [7:0] RST_SKEW_B = 8'h54;
   localparam logic [7:0] RST_HOLD_GROUP = 8'h30;
   localparam logic [7:0] RST_PERIOD = 8'h0f;
   localparam logic [7:0] RST_SYS_CTRL = 8'h20;
   localparam logic [7:0] RST_RECOVERY = 8'h02;
   localparam logic [7:0] SKEW_MASK = 8'hfc;
   localparam logic [7:0] HOLD_MASK = 8'h0f;

   localparam int SYS_SHUTDOWN_BIT = 5;
   localparam int PERIOD_DISABLE_BIT = 7;
   localparam int TRIM_DONE_BIT = 6;
   localparam int TRIM_SELECT_BIT = 1;
   localparam int NUM_CHANNELS = 4;

   localparam int CLK_HZ = 125000000;
   localparam int CYCLES_PER_US = CLK_HZ / 1000000;
   // Trim procedure duration in microseconds (a modest fixed figure).
   localparam int TRIM_TIME_US = 100;
   localparam int TRIM_CYCLES = TRIM_TIME_US * CYCLES_PER_US;
   localparam int RECOVERY_STEP_MS_X2 = 299;
   localparam int RECOVERY_MAX_MS = 1496;
endpackage

/* design/period_lookup.sv */
/*
 Maps a 5-bit soft start/stop code to a period in tenths of a millisecond.
 Assumes a purely combinational use by the control bank.
*/
`timescale 1ns/1ps
module period_lookup
(
   input wire logic [4:0] code,
   output logic [17:0] tenths_ms
);
   // ==========================================================
   // Table
   always_comb
   begin
      case (code)
         5'h08: tenths_ms = 18'd165;
         5'h09: tenths_ms = 18'd239;
         5'h0a: tenths_ms = 18'd314;
         5'h0b: tenths_ms = 18'd404;
         5'h0c: tenths_ms = 18'd539;
         5'h0d: tenths_ms = 18'd703;
         5'h0e: tenths_ms = 18'd942;
         5'h0f: tenths_ms = 18'd1257;
         5'h10: tenths_ms = 18'd1646;
         5'h11: tenths_ms = 18'd2394;
         5'h12: tenths_ms = 18'd3142;
         5'h13: tenths_ms = 18'd4039;
         5'h14: tenths_ms = 18'd5386;
         5'h15: tenths_ms = 18'd7031;
         5'h16: tenths_ms = 18'd9425;
         5'h17: tenths_ms = 18'd12566;
         5'h18: tenths_ms = 18'd17281;
         5'h19: tenths_ms = 18'd25136;
         5'h1a: tenths_ms = 18'd32991;
         5'h1b: tenths_ms = 18'd42417;
         5'h1c: tenths_ms = 18'd56556;
         5'h1d: tenths_ms = 18'd73837;
         5'h1e: tenths_ms = 18'd98973;
         5'h1f: tenths_ms = 18'd131964;
         default: tenths_ms = 18'd0;
      endcase
   end
endmodule

/* design/ms_timer.sv */
/*
 Down counter that runs for a given number of time units and pulses at the end.
 Assumes the caller supplies a one-cycle unit tick and a one-cycle start.
*/
`timescale 1ns/1ps
module ms_timer
#(
   parameter int WIDTH = 18
)
(
   input wire logic core_clk,
   input wire logic reset,
   input wire logic start,
   input wire logic abort,
   input wire logic unit_tick,
   input wire logic [WIDTH-1:0] units,
   output logic busy,
   output logic done
);
   logic [WIDTH-1:0] count_reg;

   // ==========================================================
   // Counter
   always_ff @(posedge core_clk)
   begin
      if (reset || abort)
      begin
         count_reg <= '0;
         busy <= 1'b0;
         done <= 1'b0;
      end
      else if (start)
      begin
         count_reg <= units;
         busy <= (units != '0);
         done <= (units == '0);
      end
      else if (busy && unit_tick)
      begin
         count_reg <= count_reg - 1'b1;
         done <= (count_reg == {{(WIDTH-1){1'b0}}, 1'b1});
         busy <= (count_reg != {{(WIDTH-1){1'b0}}, 1'b1});
      end
      else
      begin
         done <= 1'b0;
      end
   end
endmodule

/* design/pwm_ctrl_bank.sv */
/*
 Register bank and sequencing for PWM shutdown, soft start/stop and power
 stage recovery. Assumes a host on a simple strobe port in the core clock
 domain; the power-down pin and the fault line arrive asynchronously.
*/
`timescale 1ns/1ps
module pwm_ctrl_bank
   import pwm_ctrl_pkg::*;
#(
   // Cycles per tenth of a millisecond; shorten in simulation.
   parameter int TENTH_MS_CYCLES = CLK_HZ / 10000,
   parameter int TRIM_CYC = TRIM_CYCLES
)
(
   input wire logic core_clk,
   input wire logic reset,
   input wire logic [7:0] reg_addr,
   input wire logic [7:0] reg_wdata,
   input wire logic reg_write,
   input wire logic reg_read,
   output logic [7:0] reg_rdata,
   input wire logic power_down_pin,
   input wire logic power_stage_fault,
   output logic [3:0] channel_run,
   output logic pwm_half_duty,
   output logic power_stage_reset,
   output logic [7:0] skew_ch1,
   output logic [7:0] skew_ch2,
   output logic [7:0] skew_ch1_inv,
   output logic [7:0] skew_ch2_inv,
   output logic factory_trim_en
);
   typedef enum logic [2:0] {ST_OFF, ST_SOFT_START, ST_RUN, ST_SOFT_STOP,
                             ST_FAULT_WAIT} seq_state_t;

   logic [7:0] skew_reg [4];
   logic [7:0] hold_group_reg;
   logic [7:0] period_reg;
   logic [7:0] sys_ctrl_reg;
   logic trim_select_reg;
   logic trim_done_reg;
   logic trim_busy_reg;
   logic [31:0] trim_count_reg;
   logic [3:0] recovery_reg;
   logic recovery_locked_reg;
   logic [1:0] pdn_sync_reg;
   logic [1:0] fault_sync_reg;
   logic [31:0] tick_count_reg;
   logic unit_tick;
   seq_state_t state_reg;
   seq_state_t state_next;
   logic [17:0] period_tenths;
   logic [17:0] recovery_tenths;
   logic [17:0] timer_units;
   logic timer_start;
   logic timer_busy;
   logic timer_done;
   logic want_run;
   logic fault_now;
   logic wr;

   assign wr = reg_write;

   // ==========================================================
   // Input synchronisers
   always_ff @(posedge core_clk)
   begin
      if (reset)
      begin
         pdn_sync_reg <= 2'b00;
         fault_sync_reg <= 2'b00;
      end
      else
      begin
         pdn_sync_reg <= {pdn_sync_reg[0], power_down_pin};
         fault_sync_reg <= {fault_sync_reg[0], power_stage_fault};
      end
   end

   assign fault_now = fault_sync_reg[1];

   // ==========================================================
   // Skew registers
   always_ff @(posedge core_clk)
   begin
      if (reset)
      begin
         skew_reg[0] <= RST_SKEW_A;
         skew_reg[1] <= RST_SKEW_B;
         skew_reg[2] <= RST_SKEW_A;
         skew_reg[3] <= RST_SKEW_B;
      end
      else if (wr && reg_addr >= ADDR_SKEW1 && reg_addr <= ADDR_SKEW2_INV)
      begin
         // Low two bits are reserved and always read zero.
         skew_reg[2'(reg_addr - ADDR_SKEW1)] <= reg_wdata & SKEW_MASK;
      end
   end

   assign skew_ch1 = skew_reg[0];
   assign skew_ch2 = skew_reg[1];
   assign skew_ch1_inv = skew_reg[2];
   assign skew_ch2_inv = skew_reg[3];

   // ==========================================================
   // Hold group, period and system control
   always_ff @(posedge core_clk)
   begin
      if (reset)
      begin
         hold_group_reg <= RST_HOLD_GROUP;
         period_reg <= RST_PERIOD;
         sys_ctrl_reg <= RST_SYS_CTRL;
      end
      else if (wr)
      begin
         if (reg_addr == ADDR_HOLD_GROUP)
            hold_group_reg <= reg_wdata;
         if (reg_addr == ADDR_PERIOD)
            period_reg <= reg_wdata & 8'h9f;
         if (reg_addr == ADDR_SYS_CTRL)
            sys_ctrl_reg <= reg_wdata;
      end
   end

   // ==========================================================
   // Oscillator trim
   always_ff @(posedge core_clk)
   begin
      if (reset)
      begin
         trim_select_reg <= 1'b1;
         trim_done_reg <= 1'b0;
         trim_busy_reg <= 1'b0;
         trim_count_reg <= '0;
      end
      else if (wr && reg_addr == ADDR_TRIM)
      begin
         trim_select_reg <= reg_wdata[TRIM_SELECT_BIT];
         trim_done_reg <= 1'b0;
         trim_busy_reg <= 1'b1;
         trim_count_reg <= 32'(TRIM_CYC);
      end
      else if (trim_busy_reg)
      begin
         if (trim_count_reg <= 32'd1)
         begin
            trim_busy_reg <= 1'b0;
            trim_done_reg <= 1'b1;
         end
         trim_count_reg <= trim_count_reg - 32'd1;
      end
   end

   assign factory_trim_en = ~trim_select_reg;

   // ==========================================================
   // Power stage recovery wait, writable once per reset
   always_ff @(posedge core_clk)
   begin
      if (reset)
      begin
         recovery_reg <= RST_RECOVERY[3:0];
         recovery_locked_reg <= 1'b0;
      end
      else if (wr && reg_addr == ADDR_RECOVERY && !recovery_locked_reg)
      begin
         recovery_reg <= reg_wdata[3:0];
         recovery_locked_reg <= 1'b1;
      end
   end

   // The waits are kept as tabulated; a computed step drifts from them by up to 1 ms.
   always_comb
   begin
      case (recovery_reg)
         // Reserved codes 0 and 1 fall back to the shortest wait.
         4'h0, 4'h1, 4'h2: recovery_tenths = 18'd2990;
         4'h3: recovery_tenths = 18'd4490;
         4'h4: recovery_tenths = 18'd5980;
         4'h5: recovery_tenths = 18'd7480;
         4'h6: recovery_tenths = 18'd8980;
         4'h7: recovery_tenths = 18'd10470;
         4'h8: recovery_tenths = 18'd11970;
         4'h9: recovery_tenths = 18'd13460;
         default: recovery_tenths = 18'(RECOVERY_MAX_MS * 10);
      endcase
   end

   // ==========================================================
   // Tenth-millisecond tick
   always_ff @(posedge core_clk)
   begin
      if (reset || tick_count_reg >= 32'(TENTH_MS_CYCLES - 1))
         tick_count_reg <= '0;
      else
         tick_count_reg <= tick_count_reg + 32'd1;
   end

   assign unit_tick = (tick_count_reg == 32'(TENTH_MS_CYCLES - 1));

   period_lookup u_period
   (
      .code(period_reg[4:0]),
      .tenths_ms(period_tenths)
   );

   // ==========================================================
   // Start/stop sequencer
   // Running is wanted only out of shutdown and with the power-down pin high.
   assign want_run = !sys_ctrl_reg[SYS_SHUTDOWN_BIT] && pdn_sync_reg[1];

   always_ff @(posedge core_clk)
   begin
      if (reset)
      begin
         state_reg <= ST_OFF;
      end
      else
      begin
         state_reg <= state_next;
      end
   end

   always_comb
   begin
      state_next = state_reg;
      timer_start = 1'b0;
      timer_units = period_tenths;
      if (period_reg[PERIOD_DISABLE_BIT])
         timer_units = '0;
      case (state_reg)
         ST_OFF:
            if (want_run && !fault_now)
            begin
               // A zero period skips the 50% duty phase altogether.
               state_next = (timer_units == '0) ? ST_RUN : ST_SOFT_START;
               timer_start = 1'b1;
            end
         ST_SOFT_START:
            if (fault_now)
            begin
               state_next = ST_FAULT_WAIT;
               timer_start = 1'b1;
               timer_units = recovery_tenths;
            end
            else if (!want_run)
               state_next = ST_OFF;
            else if (timer_done || !timer_busy)
               state_next = ST_RUN;
         ST_RUN:
            if (fault_now)
            begin
               state_next = ST_FAULT_WAIT;
               timer_start = 1'b1;
               timer_units = recovery_tenths;
            end
            else if (!want_run)
            begin
               state_next = (timer_units == '0) ? ST_OFF : ST_SOFT_STOP;
               timer_start = 1'b1;
            end
         ST_SOFT_STOP:
            if (timer_done || !timer_busy)
               state_next = ST_OFF;
         ST_FAULT_WAIT:
            if (!timer_busy && !fault_now)
               state_next = ST_OFF;
            else if (!timer_busy)
            begin
               timer_start = 1'b1;
               timer_units = recovery_tenths;
            end
         default:
            state_next = ST_OFF;
      endcase
   end

   ms_timer #(.WIDTH(18)) u_timer
   (
      .core_clk(core_clk),
      .reset(reset),
      .start(timer_start),
      .abort(1'b0),
      .unit_tick(unit_tick),
      .units(timer_units),
      .busy(timer_busy),
      .done(timer_done)
   );

   // ==========================================================
   // Outputs
   always_ff @(posedge core_clk)
   begin
      if (reset)
      begin
         channel_run <= 4'h0;
         pwm_half_duty <= 1'b0;
         power_stage_reset <= 1'b1;
      end
      else
      begin
         // Held channels never start on a shutdown exit.
         channel_run <= (state_next == ST_RUN) ? ~hold_group_reg[3:0] : 4'h0;
         pwm_half_duty <= (state_next == ST_SOFT_START) || (state_next == ST_SOFT_STOP);
         power_stage_reset <= (state_next == ST_FAULT_WAIT) || (state_next == ST_OFF);
      end
   end

   // ==========================================================
   // Register read
   always_ff @(posedge core_clk)
   begin
      if (reset)
         reg_rdata <= 8'h00;
      else if (reg_read)
      begin
         case (reg_addr)
            ADDR_SYS_CTRL: reg_rdata <= sys_ctrl_reg;
            ADDR_SKEW1: reg_rdata <= skew_reg[0];
            ADDR_SKEW2: reg_rdata <= skew_reg[1];
            ADDR_SKEW1_INV: reg_rdata <= skew_reg[2];
            ADDR_SKEW2_INV: reg_rdata <= skew_reg[3];
            ADDR_HOLD_GROUP: reg_rdata <= hold_group_reg;
            ADDR_PERIOD: reg_rdata <= period_reg;
            ADDR_TRIM: reg_rdata <= {1'b0, trim_done_reg, 4'h0, trim_select_reg, 1'b0};
            ADDR_RECOVERY: reg_rdata <= {4'h0, recovery_reg};
            ADDR_STATUS: reg_rdata <= {5'h0, 3'(state_reg)};
            default: reg_rdata <= 8'h00;
         endcase
      end
      else
         reg_rdata <= 8'h00;
   end

   // ==========================================================
   // Checks
   chk_reset_skew: assert property (@(posedge core_clk)
      $fell(reset) |-> skew_reg[0] == RST_SKEW_A && skew_reg[1] == RST_SKEW_B)
      else $error("skew reset value wrong");
   chk_hold_stop: assert property (@(posedge core_clk) disable iff (reset)
      (channel_run & hold_group_reg[3:0]) == 4'h0 || $changed(hold_group_reg))
      else $error("held channel running");
   chk_trim_done: assert property (@(posedge core_clk) disable iff (reset)
      (wr && reg_addr == ADDR_TRIM) |=> !trim_done_reg)
      else $error("trim done not cleared");
   chk_recovery_once: assert property (@(posedge core_clk) disable iff (reset)
      recovery_locked_reg |=> $stable(recovery_reg))
      else $error("recovery changed after lock");
   chk_fault_halt: assert property (@(posedge core_clk) disable iff (reset)
      (state_reg == ST_RUN && fault_now) |=> channel_run == 4'h0)
      else $error("pwm not halted on fault");
   chk_shutdown_off: assert property (@(posedge core_clk) disable iff (reset)
      (sys_ctrl_reg[SYS_SHUTDOWN_BIT] && state_reg == ST_RUN) |=> state_reg != ST_RUN)
      else $error("shutdown ignored");
   chk_period_none: assert property (@(posedge core_clk) disable iff (reset)
      (timer_start && timer_units == '0) |=> !timer_busy)
      else $error("zero period ran");
   chk_trim_select: assert property (@(posedge core_clk) disable iff (reset)
      (wr && reg_addr == ADDR_TRIM && reg_wdata == 8'h00) |=> factory_trim_en)
      else $error("factory trim not enabled");
   cov_start: cover property (@(posedge core_clk) state_reg == ST_SOFT_START ##1 state_reg == ST_RUN);
   cov_fault: cover property (@(posedge core_clk) state_reg == ST_FAULT_WAIT);
   cov_stop: cover property (@(posedge core_clk) state_reg == ST_SOFT_STOP);
endmodule

/* verif/host_model.sv */
/*
 Host processor model: drives the register port of the control bank.
 Assumes the strobe port of the bank and one 125 MHz core clock.
*/
`timescale 1ns/1ps
module host_model
(
   input wire logic core_clk,
   input wire logic [7:0] reg_rdata,
   output logic [7:0] reg_addr,
   output logic [7:0] reg_wdata,
   output logic reg_write,
   output logic reg_read
);
   import pwm_ctrl_pkg::*;

   initial
   begin
      reg_addr = 8'h00;
      reg_wdata = 8'h00;
      reg_write = 1'b0;
      reg_read = 1'b0;
   end

   // ==========================================================
   // Bus cycles
   task automatic write_reg(input logic [7:0] addr, input logic [7:0] data);
      @(posedge core_clk);
      reg_addr <= addr;
      reg_wdata <= data;
      reg_write <= 1'b1;
      @(posedge core_clk);
      reg_write <= 1'b0;
   endtask

   // Read data stand only in the cycle after the strobe, so sample just then.
   task automatic read_reg(input logic [7:0] addr, output logic [7:0] data);
      @(posedge core_clk);
      reg_addr <= addr;
      reg_read <= 1'b1;
      @(posedge core_clk);
      reg_read <= 1'b0;
      #1;
      data = reg_rdata;
   endtask

   // ==========================================================
   // Host duties
   task automatic start_trim();
      write_reg(ADDR_TRIM, 8'h00);
   endtask

   task automatic load_three_level();
      write_reg(ADDR_SKEW1, 8'hb8);
      write_reg(ADDR_SKEW2, 8'h60);
      write_reg(ADDR_SKEW1_INV, 8'ha0);
      write_reg(ADDR_SKEW2_INV, 8'h48);
   endtask

   task automatic set_output_mode(input logic parallel);
      write_reg(ADDR_HOLD_GROUP, parallel ? 8'h3a : 8'h30);
   endtask
endmodule

/* verif/pwm_shutdown_startstop_ctrl_bench.sv */
/*
 Self-checking bench for the PWM shutdown and soft start/stop bank.
 Assumes the bank is built with shortened tenth-ms and trim counts.
*/
`timescale 1ns/1ps
module pwm_shutdown_startstop_ctrl_bench;
   import pwm_ctrl_pkg::*;

   localparam int TENTH = 4;
   localparam int TRIMC = 5;

   logic core_clk = 1'b0;
   logic reset = 1'b1;
   logic [7:0] reg_addr, reg_wdata, reg_rdata, rd;
   logic reg_write, reg_read;
   logic power_down_pin = 1'b1;
   logic power_stage_fault = 1'b0;
   logic [3:0] channel_run;
   logic pwm_half_duty, power_stage_reset, factory_trim_en;
   logic [7:0] skew_ch1, skew_ch2, skew_ch1_inv, skew_ch2_inv;
   int num_errors = 0;
   int check_count = 0;
   int n;

   always #4 core_clk = ~core_clk;

   host_model host (.core_clk(core_clk), .reg_rdata(reg_rdata), .reg_addr(reg_addr),
      .reg_wdata(reg_wdata), .reg_write(reg_write), .reg_read(reg_read));

   pwm_ctrl_bank #(.TENTH_MS_CYCLES(TENTH), .TRIM_CYC(TRIMC)) uut (.core_clk(core_clk),
      .reset(reset), .reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_write(reg_write),
      .reg_read(reg_read), .reg_rdata(reg_rdata), .power_down_pin(power_down_pin),
      .power_stage_fault(power_stage_fault), .channel_run(channel_run),
      .pwm_half_duty(pwm_half_duty), .power_stage_reset(power_stage_reset),
      .skew_ch1(skew_ch1), .skew_ch2(skew_ch2), .skew_ch1_inv(skew_ch1_inv),
      .skew_ch2_inv(skew_ch2_inv), .factory_trim_en(factory_trim_en));

   // ==========================================================
   // Shared helpers
   task automatic check(input logic [31:0] seen, input logic [31:0] expected);
      check_count++;
      if (seen !== expected)
      begin
         num_errors++;
         $display("wrong value at %0t: seen %h expected %h", $time, seen, expected);
      end
   endtask

   task automatic finish_test();
      $display("checks %0d, mismatches %0d", check_count, num_errors);
      if (num_errors == 0 && check_count > 0)
         $display("Testbench passed");
      else
         $display("Testbench failed");
      $finish;
   endtask

   function automatic logic probe(input int sel);
      return sel != 0 ? power_stage_reset : pwm_half_duty;
   endfunction

   // Waits a bounded time for the signal to rise, then counts its high cycles.
   task automatic count_high(input int sel, input int wait_max, output int cnt);
      int w;
      w = 0;
      cnt = 0;
      while (probe(sel) !== 1'b1 && w < wait_max)
      begin
         @(posedge core_clk);
         #1;
         w++;
      end
      while (probe(sel) === 1'b1 && cnt < 30000)
      begin
         @(posedge core_clk);
         #1;
         cnt++;
      end
   endtask

   task automatic idle(input int cyc);
      repeat (cyc) @(posedge core_clk);
      #1;
   endtask

   // ==========================================================
   // Scenarios
   task automatic test_reset_values();
      logic [7:0] exp_rst [5] = '{8'hac, 8'h54, 8'hac, 8'h54, 8'h30};
      logic [7:0] addrs [5] = '{ADDR_SKEW1, ADDR_SKEW2, ADDR_SKEW1_INV, ADDR_SKEW2_INV,
         ADDR_HOLD_GROUP};
      for (int i = 0; i < 5; i++)
      begin
         host.read_reg(addrs[i], rd);
         check(rd, exp_rst[i]);
      end
      host.read_reg(ADDR_PERIOD, rd);
      check(rd, 8'h0f);
      host.read_reg(ADDR_TRIM, rd);
      check({rd[6], rd[1]}, 2'b01);
      check(factory_trim_en, 1'b0);
      host.read_reg(8'h30, rd);
      check(rd, 8'h00);
      check({channel_run, power_stage_reset}, 5'h01);
      $display("test reset values done");
   endtask

   task automatic test_trim();
      host.start_trim();
      idle(TRIMC + 10);
      host.read_reg(ADDR_TRIM, rd);
      check({rd[6], rd[1]}, 2'b10);
      check(factory_trim_en, 1'b1);
      $display("test trim done");
   endtask

   task automatic test_skew();
      host.load_three_level();
      // Reserved low bits must read back as zero.
      host.write_reg(ADDR_SKEW2_INV, 8'h4b);
      host.read_reg(ADDR_SKEW2_INV, rd);
      check(rd, 8'h48);
      check({skew_ch1, skew_ch2, skew_ch1_inv, skew_ch2_inv}, 32'hb860a048);
      $display("test skew done");
   endtask

   task automatic test_group_start();
      host.set_output_mode(1'b1);
      host.write_reg(ADDR_PERIOD, 8'h08);
      host.write_reg(ADDR_SYS_CTRL, 8'h00);
      #1;
      count_high(0, 50, n);
      check(n >= 165 * TENTH - 10 && n <= 165 * TENTH + 20, 1'b1);
      idle(5);
      check(channel_run, 4'h5);
      host.write_reg(ADDR_SYS_CTRL, 8'h20);
      #1;
      count_high(0, 50, n);
      check(n >= 165 * TENTH - 10 && n <= 165 * TENTH + 20, 1'b1);
      idle(5);
      check({channel_run, power_stage_reset}, 5'h01);
      $display("test group start done");
   endtask

   task automatic quick_start(input logic [7:0] per);
      host.write_reg(ADDR_PERIOD, per);
      host.read_reg(ADDR_PERIOD, rd);
      check(rd, per);
      host.write_reg(ADDR_SYS_CTRL, 8'h00);
      count_high(0, 20, n);
      check(n, 0);
      check(channel_run, 4'h5);
      host.write_reg(ADDR_SYS_CTRL, 8'h20);
      count_high(0, 20, n);
      check({n[3:0], channel_run}, 8'h00);
      $display("test quick start done");
   endtask

   task automatic test_power_down_pin();
      host.write_reg(ADDR_PERIOD, 8'h08);
      host.write_reg(ADDR_SYS_CTRL, 8'h00);
      // Start, then drop and raise the pin: each change gets a soft stop or start.
      for (int i = 0; i < 3; i++)
      begin
         if (i > 0)
            power_down_pin <= (i == 2);
         #1;
         count_high(0, 50, n);
         check(n >= 165 * TENTH - 10 && n <= 165 * TENTH + 20, 1'b1);
         idle(5);
         check({channel_run, power_stage_reset}, (i == 1) ? 5'h01 : 5'h0a);
         @(posedge core_clk);
      end
      host.read_reg(ADDR_STATUS, rd);
      check(rd, 8'h02);
      $display("test power down pin done");
   endtask

   task automatic test_recovery();
      host.write_reg(ADDR_RECOVERY, 8'h03);
      host.write_reg(ADDR_RECOVERY, 8'h09);
      host.read_reg(ADDR_RECOVERY, rd);
      check(rd & 8'h0f, 8'h03);
      host.write_reg(ADDR_PERIOD, 8'h80);
      host.write_reg(ADDR_SYS_CTRL, 8'h00);
      idle(20);
      check(channel_run, 4'h5);
      @(posedge core_clk);
      power_stage_fault <= 1'b1;
      repeat (6) @(posedge core_clk);
      power_stage_fault <= 1'b0;
      #1;
      check({channel_run, power_stage_reset}, 5'h01);
      count_high(1, 5, n);
      check(n >= 4490 * TENTH - 10 && n <= 4490 * TENTH + 30, 1'b1);
      idle(20);
      check(channel_run, 4'h5);
      $display("test recovery done");
   endtask

   task automatic test_second_reset();
      @(posedge core_clk);
      reset <= 1'b1;
      repeat (5) @(posedge core_clk);
      reset <= 1'b0;
      host.read_reg(ADDR_RECOVERY, rd);
      check(rd & 8'h0f, 8'h02);
      check({skew_ch1, channel_run}, 12'hac0);
      host.read_reg(ADDR_TRIM, rd);
      check({factory_trim_en, rd[6], rd[1]}, 3'b001);
      host.start_trim();
      host.write_reg(ADDR_RECOVERY, 8'h05);
      host.read_reg(ADDR_RECOVERY, rd);
      check(rd & 8'h0f, 8'h05);
      idle(TRIMC + 10);
      host.read_reg(ADDR_TRIM, rd);
      check(rd[6], 1'b1);
      $display("test second reset done");
   endtask

   // ==========================================================
   // Main sequence and watchdog
   initial
   begin
      repeat (5) @(posedge core_clk);
      reset <= 1'b0;
      test_reset_values();
      test_trim();
      test_skew();
      test_group_start();
      quick_start(8'h00);
      quick_start(8'h88);
      test_power_down_pin();
      test_recovery();
      test_second_reset();
      finish_test();
   end

   // The whole run is near 22,000 cycles; this allows over three times that.
   initial
   begin
      #600000;
      num_errors++;
      finish_test();
   end
endmodule
